// file: hdl/crirq_pkg.sv
// Package of register map, field positions and reset values for the clock ready irq block
package crirq_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFS_CLOCK_INTERRUPT_CONTROL = 12'h008;
  localparam logic [11:0] OFS_PERIPHERAL_RESET_GROUP2 = 12'h00C;
  localparam logic [11:0] OFS_IRQ_STATUS              = 12'h010;
  localparam logic [11:0] OFS_IRQ_CLEAR               = 12'h014;
  localparam logic [11:0] OFS_IRQ_ENABLE              = 12'h018;

  // ****************************************************************
  // Clock interrupt control field positions
  // ****************************************************************
  localparam int READY_FLAG_LSB   = 0;   // Six ready flags, bits 5:0
  localparam int CLOCK_FAIL_BIT   = 7;   // Clock security flag
  localparam int READY_ENABLE_LSB = 8;   // Six ready enables, bits 13:8
  localparam int READY_CLEAR_LSB  = 16;  // Six write-one clears, bits 21:16
  localparam int CLOCK_FAIL_CLEAR = 23;  // Clock security flag clear
  localparam int NUM_SOURCES      = 6;

  // ****************************************************************
  // Peripheral reset group 2 field positions
  // ****************************************************************
  localparam int RST_SYSCONFIG = 0;
  localparam int RST_CONVERTER = 9;
  localparam int RST_TIMER_ONE = 11;
  localparam int RST_SERIAL    = 12;
  localparam int RST_PORT_ONE  = 14;
  localparam int RST_TIMER_SEV = 16;
  localparam int RST_DEBUG     = 22;
  localparam logic [31:0] PRST2_MASK = 32'h00415A01;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RESET_CLOCK_INTERRUPT_CONTROL = 32'h00000000;
  localparam logic [31:0] RESET_PERIPHERAL_GROUP2       = 32'h00000000;
  localparam logic [6:0]  RESET_IRQ_ENABLE              = 7'h7F;

  // Event status layout: bits 5:0 ready events, bit 6 clock fail event
  localparam int NUM_EVENTS = 7;

endpackage : crirq_pkg

// file: hdl/crirq_top.sv
// Clock ready interrupt flags, clock security flag and peripheral reset register 2
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

// Contract
// - Low internal osc ready sets bit 0
// - Low external osc ready sets bit 1
// - High internal osc ready sets bit 2
// - High external osc ready sets bit 3
// - PLL lock sets bit 4
// - 14 MHz osc ready sets bit 5
// - External osc failure always sets bit 7
// - Ready enables in bits 8 to 13
// - Write one to bits 16-21 clears flags
// - Write one to bit 23 clears fail flag
// - Byte, half, word access, no waits
// - Reset bits hold peripherals in reset
module crirq_top (
  // Clock, reset and enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator status from the analog side (asynchronous levels)
  input  wire logic        low_speed_internal_osc,
  input  wire logic        low_speed_external_osc,
  input  wire logic        high_speed_internal_osc,
  input  wire logic        high_speed_external_osc,
  input  wire logic        pll_locked,
  input  wire logic        internal_14mhz_osc,
  input  wire logic        external_osc_failed,
  // Peripheral resets
  output logic             sysconfig_unit_reset,
  output logic             converter_reset,
  output logic             timer_one_reset,
  output logic             serial_periph_reset,
  output logic             serial_port_one_reset,
  output logic             timer_seven_reset,
  output logic             debug_unit_reset,
  // Interrupts
  output logic             clock_irq,
  output logic             event_irq
);

  localparam int NS = crirq_pkg::NUM_SOURCES;
  localparam int NE = crirq_pkg::NUM_EVENTS;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [6:0]    sync1;        // First synchroniser stage
    logic [6:0]    sync2;        // Second synchroniser stage
    logic [6:0]    last;         // Previous synchronised level
    logic [NS-1:0] ready_flag;   // Ready flags
    logic          fail_flag;    // Clock security flag
    logic [NS-1:0] ready_enable; // Ready interrupt enables
    logic [31:0]   prst2;        // Peripheral reset group 2
    logic [NE-1:0] ev_status;    // Sticky event status
    logic [NE-1:0] ev_enable;    // Event interrupt enables
    logic [31:0]   rdata;        // Registered read data
  } crirq_state_type;

  crirq_state_type state;
  crirq_state_type next_state;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Expand byte strobes into a bit mask
  function automatic logic [31:0] crirq_lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : crirq_lane_mask

  // Merge written lanes into an old value
  function automatic logic [31:0] crirq_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction : crirq_merge

  // Register select, shared by the clear and read decoders; register writes decode paddr in a case
  function automatic logic crirq_addr_hit(input logic [11:0] addr,
                                          input logic [11:0] ofs);
    return addr == ofs;
  endfunction : crirq_addr_hit

  // Control register image as software sees it
  function automatic logic [31:0] crirq_ctrl_image(input crirq_state_type s);
    logic [31:0] v;
    v = 32'h00000000;
    v[crirq_pkg::READY_FLAG_LSB +: NS]   = s.ready_flag;
    v[crirq_pkg::CLOCK_FAIL_BIT]         = s.fail_flag;
    v[crirq_pkg::READY_ENABLE_LSB +: NS] = s.ready_enable;
    return v;
  endfunction : crirq_ctrl_image

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        wr_phase;
  logic        rd_setup;
  logic [31:0] lane_mask;
  logic [31:0] wmask;
  logic [6:0]  level;
  logic [6:0]  rise;
  logic [NS-1:0] ready_set;
  logic          fail_set;
  logic [NE-1:0] ev_set;
  logic [NS-1:0] ready_clr;
  logic          fail_clr;
  logic          hit_ctrl;
  logic          hit_prst2;
  logic          hit_status;
  logic          hit_clear;
  logic          hit_enable;
  logic          ctrl_write;
  logic [6:0]    raw_level;

  // Writes commit in the access phase; reads are captured at setup
  assign wr_phase  = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign lane_mask = crirq_lane_mask(pstrb);
  assign wmask     = pwdata & lane_mask;

  // Register selects; a write to the control register drives the clears
  assign hit_ctrl   = crirq_addr_hit(paddr, crirq_pkg::OFS_CLOCK_INTERRUPT_CONTROL);
  assign hit_prst2  = crirq_addr_hit(paddr, crirq_pkg::OFS_PERIPHERAL_RESET_GROUP2);
  assign hit_status = crirq_addr_hit(paddr, crirq_pkg::OFS_IRQ_STATUS);
  assign hit_clear  = crirq_addr_hit(paddr, crirq_pkg::OFS_IRQ_CLEAR);
  assign hit_enable = crirq_addr_hit(paddr, crirq_pkg::OFS_IRQ_ENABLE);
  assign ctrl_write = wr_phase & hit_ctrl;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = state.rdata;

  // ****************************************************************
  // Named views of the control register fields
  // ****************************************************************
  // Ready flags and the clock security flag
  logic          lowint_osc_ready_flag;
  logic          lowext_osc_ready_flag;
  logic          highint_osc_ready_flag;
  logic          highext_osc_ready_flag;
  logic          pll_lock_ready_flag;
  logic          osc14_ready_flag;
  logic          clock_fail_flag;
  // Ready interrupt enables
  logic          lowint_osc_irq_enable;
  logic          lowext_osc_irq_enable;
  logic          highint_osc_irq_enable;
  logic          highext_osc_irq_enable;
  logic          pll_lock_irq_enable;
  logic          osc14_irq_enable;
  // Write-one clear strobes
  logic          lowint_osc_flag_clear;
  logic          lowext_osc_flag_clear;
  logic          highint_osc_flag_clear;
  logic          highext_osc_flag_clear;
  logic          pll_lock_flag_clear;
  logic          osc14_flag_clear;
  logic          clock_fail_flag_clear;

  // Flags and enables as stored
  assign lowint_osc_ready_flag  = state.ready_flag[0];
  assign lowext_osc_ready_flag  = state.ready_flag[1];
  assign highint_osc_ready_flag = state.ready_flag[2];
  assign highext_osc_ready_flag = state.ready_flag[3];
  assign pll_lock_ready_flag    = state.ready_flag[4];
  assign osc14_ready_flag       = state.ready_flag[5];
  assign clock_fail_flag        = state.fail_flag;
  assign lowint_osc_irq_enable  = state.ready_enable[0];
  assign lowext_osc_irq_enable  = state.ready_enable[1];
  assign highint_osc_irq_enable = state.ready_enable[2];
  assign highext_osc_irq_enable = state.ready_enable[3];
  assign pll_lock_irq_enable    = state.ready_enable[4];
  assign osc14_irq_enable       = state.ready_enable[5];

  // A zero or an unstrobed lane leaves its flag alone
  // ready flag and fail flag clears
  assign lowint_osc_flag_clear  = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 0];
  assign lowext_osc_flag_clear  = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 1];
  assign highint_osc_flag_clear = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 2];
  assign highext_osc_flag_clear = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 3];
  assign pll_lock_flag_clear    = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 4];
  assign osc14_flag_clear       = ctrl_write & wmask[crirq_pkg::READY_CLEAR_LSB + 5];
  assign clock_fail_flag_clear  = ctrl_write & wmask[crirq_pkg::CLOCK_FAIL_CLEAR];

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // Pin levels in event order; bit 6 is the failure detector
  assign raw_level = {external_osc_failed,
                      internal_14mhz_osc,
                      pll_locked,
                      high_speed_external_osc,
                      high_speed_internal_osc,
                      low_speed_external_osc,
                      low_speed_internal_osc};

  // Only the second stage is read: the first stage may be metastable
  assign level = state.sync2;
  assign rise  = level & ~state.last;

  assign ready_set = rise[NS-1:0] & {osc14_irq_enable,
                                     pll_lock_irq_enable,
                                     highext_osc_irq_enable,
                                     highint_osc_irq_enable,
                                     lowext_osc_irq_enable,
                                     lowint_osc_irq_enable};
  assign fail_set  = rise[6];
  assign ev_set    = {fail_set, ready_set};

  assign ready_clr = {osc14_flag_clear,
                      pll_lock_flag_clear,
                      highext_osc_flag_clear,
                      highint_osc_flag_clear,
                      lowext_osc_flag_clear,
                      lowint_osc_flag_clear};
  assign fail_clr  = clock_fail_flag_clear;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    // Two-stage synchroniser, then the edge memory
    next_state.sync1 = raw_level;
    next_state.sync2 = state.sync1;
    next_state.last  = level;

    // Set wins over a clear in the same cycle
    next_state.ready_flag = (state.ready_flag & ~ready_clr) | ready_set;
    next_state.fail_flag  = (state.fail_flag & ~fail_clr) | fail_set;

    // Register writes
    if (wr_phase) begin
      unique case (paddr)
        crirq_pkg::OFS_CLOCK_INTERRUPT_CONTROL: begin
          for (int i = 0; i < NS; i++) begin
            if (lane_mask[crirq_pkg::READY_ENABLE_LSB + i]) begin
              next_state.ready_enable[i] = pwdata[crirq_pkg::READY_ENABLE_LSB + i];
            end
          end
        end
        crirq_pkg::OFS_PERIPHERAL_RESET_GROUP2: begin
          next_state.prst2 = crirq_merge(state.prst2, pwdata, lane_mask)
                             & crirq_pkg::PRST2_MASK;
        end
        crirq_pkg::OFS_IRQ_ENABLE: begin
          next_state.ev_enable = (state.ev_enable & ~lane_mask[NE-1:0])
                                 | (pwdata[NE-1:0] & lane_mask[NE-1:0]);
        end
        default: begin
        end
      endcase
    end

    // Sticky status: set wins over a write-one clear
    next_state.ev_status = state.ev_status | ev_set;
    if (wr_phase && hit_clear) begin
      next_state.ev_status = (state.ev_status & ~wmask[NE-1:0]) | ev_set;
    end

    // Read data, unmapped addresses read zero; clear register reads zero
    if (rd_setup) begin
      if (hit_ctrl) begin
        next_state.rdata = crirq_ctrl_image(state);
      end else if (hit_prst2) begin
        next_state.rdata = state.prst2;
      end else if (hit_status) begin
        next_state.rdata = {25'h0, state.ev_status};
      end else if (hit_enable) begin
        next_state.rdata = {25'h0, state.ev_enable};
      end else begin
        // Clear register and gaps hold nothing readable
        next_state.rdata = 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Synchronous reset; clock enable freezes every bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state              <= '0;
      state.ready_enable <= crirq_pkg::RESET_CLOCK_INTERRUPT_CONTROL[crirq_pkg::READY_ENABLE_LSB +: NS];
      state.prst2        <= crirq_pkg::RESET_PERIPHERAL_GROUP2;
      state.ev_enable    <= crirq_pkg::RESET_IRQ_ENABLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // peripheral reset levels
  assign sysconfig_unit_reset  = state.prst2[crirq_pkg::RST_SYSCONFIG];
  assign converter_reset       = state.prst2[crirq_pkg::RST_CONVERTER];
  assign timer_one_reset       = state.prst2[crirq_pkg::RST_TIMER_ONE];
  assign serial_periph_reset   = state.prst2[crirq_pkg::RST_SERIAL];
  assign serial_port_one_reset = state.prst2[crirq_pkg::RST_PORT_ONE];
  assign timer_seven_reset     = state.prst2[crirq_pkg::RST_TIMER_SEV];
  assign debug_unit_reset      = state.prst2[crirq_pkg::RST_DEBUG];

  assign clock_irq = lowint_osc_ready_flag
                   | lowext_osc_ready_flag
                   | highint_osc_ready_flag
                   | highext_osc_ready_flag
                   | pll_lock_ready_flag
                   | osc14_ready_flag
                   | clock_fail_flag;
  // Level interrupt from the sticky status gated by its enables
  assign event_irq = |(state.ev_status & state.ev_enable);

endmodule : crirq_top

// file: sim/crirq_props.sv
// Assertion checker for the clock ready irq block
`timescale 1ns/1ps
module crirq_props (
  // Clock and bus
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and outputs
  input wire logic        external_osc_failed,
  input wire logic        sysconfig_unit_reset,
  input wire logic        debug_unit_reset,
  input wire logic        clock_irq
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Bus phases; a frozen block takes nothing
  logic wr;
  logic rs;
  assign wr = psel && penable && pwrite && clk_en;
  assign rs = psel && !penable && !pwrite && clk_en;
  no_wait_a: assert property (pready && !pslverr) else $error("bus stalled");
  fail_set_a: assert property ($rose(external_osc_failed) && clk_en |-> ##[2:4] clock_irq)
    else $error("fail flag late");
  clr_all_a: assert property (wr && paddr == 12'h008 && pstrb[2] && pwdata[23:16] == 8'hBF
    |=> !clock_irq) else $error("clear ignored");
  rst_out_a: assert property (wr && paddr == 12'h00C && pstrb == 4'hF |=>
    sysconfig_unit_reset == $past(pwdata[0]) && debug_unit_reset == $past(pwdata[22]))
    else $error("reset outputs wrong");
  gap_zero_a: assert property (rs && paddr == 12'h020 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  prst_rd_a: assert property (rs && paddr == 12'h00C |=> prdata[0] == sysconfig_unit_reset
    && prdata[22] == debug_unit_reset && (prdata & ~crirq_pkg::PRST2_MASK) == 32'h0)
    else $error("reset register read wrong");
  ctrl_rd_a: assert property (rs && paddr == 12'h008 |=> (prdata & 32'hFFFFC040) == 32'h0)
    else $error("write-only bits read back");
  irq_hold_a: assert property (clock_irq && !(wr && paddr == 12'h008) |=> clock_irq)
    else $error("irq dropped without clear");
  fail_c: cover property ($rose(clock_irq));
  clear_c: cover property ($fell(clock_irq));
  gap_c: cover property (rs && paddr == 12'h020);
endmodule : crirq_props
bind crirq_top crirq_props u_props (.core_clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .external_osc_failed,
  .sysconfig_unit_reset, .debug_unit_reset, .clock_irq);

// file: sim/test_clock_ready_irq_and_apb_reset.sv
// Self-checking bench for the clock ready irq block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module test_clock_ready_irq_and_apb_reset;
  logic        core_clk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d, e;
  logic [3:0]  pstrb = 4'h0;
  logic [5:0]  osc = 6'h00;
  logic        fail = 0, pready, pslverr, clock_irq, event_irq;
  logic [6:0]  rst_o;
  logic [31:0] q[$];
  int          fail_count = 0, total_checks = 0, seed = 32'h8B7AF169;
  crirq_top uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_speed_internal_osc(osc[0]),
    .low_speed_external_osc(osc[1]), .high_speed_internal_osc(osc[2]),
    .high_speed_external_osc(osc[3]), .pll_locked(osc[4]), .internal_14mhz_osc(osc[5]),
    .external_osc_failed(fail), .sysconfig_unit_reset(rst_o[0]), .converter_reset(rst_o[1]),
    .timer_one_reset(rst_o[2]), .serial_periph_reset(rst_o[3]),
    .serial_port_one_reset(rst_o[4]), .timer_seven_reset(rst_o[5]),
    .debug_unit_reset(rst_o[6]), .clock_irq(clock_irq), .event_irq(event_irq));
  // ****************************************************************
  // Clock, bus tasks and read monitor
  // ****************************************************************
  initial forever #50 core_clk = ~core_clk;
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // One APB transfer; the idle edge at the end keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x,
                     input logic [3:0] s);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fail_count++; end_of_test(); end
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    q.push_back(x);
    apb(0, a, 32'h0, 4'h0);
  endtask : rd
  // Oldest note is compared at the edge where the read completes
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e = q.pop_front();
      `CHK(prdata, e)
    end
  end
  // Hang guard
  initial begin repeat (20000) @(posedge core_clk); fail_count++; end_of_test(); end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i;
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    rd(12'h018, 32'h7F);
    apb(1, 12'h008, 32'h3F00, 4'h2);
    rd(12'h008, 32'h3F00);
    d = 32'h3F00;
    // each source sets its own flag
    for (i = 0; i < 6; i++) begin
      osc[i] <= 1;
      repeat (5) @(posedge core_clk);
      d[i] = 1;
      rd(12'h008, d);
      `CHK(clock_irq, 1'b1)
    end
    // one clear at a time, zeros leave others
    for (i = 0; i < 6; i++) begin
      apb(1, 12'h008, 32'h1 << (16 + i), 4'h4);
      d[i] = 0;
      rd(12'h008, d);
    end
    `CHK(clock_irq, 1'b0)
    osc <= 6'h00;
    apb(1, 12'h008, 32'h0, 4'h2);
    osc <= 6'h3F;
    repeat (5) @(posedge core_clk);
    rd(12'h008, 32'h0);
    fail <= 1;
    repeat (5) @(posedge core_clk);
    rd(12'h008, 32'h80);
    apb(1, 12'h008, 32'h00BF0000, 4'hC);
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h7F);
    `CHK(event_irq, 1'b1)
    apb(1, 12'h014, 32'h7F, 4'hF);
    `CHK(event_irq, 1'b0)
    apb(1, 12'h018, 32'h0, 4'hF);
    fail <= 0;
    repeat (5) @(posedge core_clk);
    fail <= 1;
    repeat (5) @(posedge core_clk);
    `CHK(event_irq, 1'b0)
    apb(1, 12'h018, 32'h40, 4'hF);
    `CHK(event_irq, 1'b1)
    // random reset patterns reach the outputs
    repeat (4) begin
      d = $random(seed);
      apb(1, 12'h00C, d, 4'hF);
      rd(12'h00C, d & crirq_pkg::PRST2_MASK);
      `CHK(rst_o, {d[22], d[16], d[14], d[12], d[11], d[9], d[0]})
    end
    apb(1, 12'h00C, 32'hFFFFFFFF, 4'h2);
    d = (d & 32'hFFFF00FF) | 32'h0000FF00;
    rd(12'h00C, d & crirq_pkg::PRST2_MASK);
    clk_en <= 0;
    apb(1, 12'h00C, 32'h0, 4'hF);
    clk_en <= 1;
    rd(12'h00C, d & crirq_pkg::PRST2_MASK);
    apb(1, 12'h020, 32'hFFFFFFFF, 4'hF);
    rd(12'h020, 32'h0);
    // Mid-run reset: a fail level still high is seen as a fresh event
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rd(12'h00C, 32'h0);
    `CHK(rst_o, 7'h00)
    rd(12'h008, 32'h80);
    `CHK(clock_irq, 1'b1)
    `CHK(event_irq, 1'b1)
    end_of_test();
  end
endmodule : test_clock_ready_irq_and_apb_reset
